// File: rtl/adcr_readout.sv
// Conversion sequencer, decimation filter and two-wire readout of the converter.
// ------------------------------------------------------------------------------
// ------------------------------------------------------------------------------
`timescale 1ns/1ps
module adcr_readout
  import adcr_pkg::*;
#(
  parameter bit FAST_VARIANT = 1'b1,
  parameter int DECIM = FAST_VARIANT ? DECIM_FAST : DECIM_SLOW,
  parameter int CAL_CYC = CAL_CYCLES,
  parameter int SLEEP_CYC = SLEEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Supply monitors, high while a supply is below its threshold
  input wire logic dvdd_low,
  input wire logic avdd_low,
  // Clock source selection
  input wire logic ext_clk_seen,
  output logic osc_en,
  // Modulator side
  output logic mod_clk,
  input wire logic mod_bit,
  output logic cal_busy,
  // Host link
  input wire logic sclk,
  output logic rdy_dout
);

  localparam int LOG_D = $clog2(DECIM);
  localparam int ACC_W = 4 * LOG_D + 2;
  localparam int SHIFT = 4 * LOG_D - (RESULT_W - 1);
  localparam int DIV_W = $clog2(MOD_DIV);

  // ----------------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------------
  if (DECIM < 4 || SHIFT < 0 || CAL_CYC < 1 || SLEEP_CYC < 1) begin : g_bad_param
    $error("adcr_readout: decimation, calibration or sleep count out of range.");
  end

  adcr_state_type state_ff;
  logic [2:0] sclk_sync_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic [PCNT_W-1:0] pulse_cnt_ff;
  logic [31:0] timer_ff;
  logic [RESULT_W-1:0] shreg_ff;
  logic cal_after_wake_ff;
  logic single_ff;
  logic [$clog2(GLITCH_CYCLES+1)-1:0] glitch_cnt_ff;
  logic por_event;
  logic [DIV_W-1:0] div_ff;
  logic mod_tick;
  logic filt_run;
  logic [31:0] dec_cnt_ff;
  logic signed [ACC_W-1:0] integ_ff [4];
  logic signed [ACC_W-1:0] comb_dly_ff [4];
  logic signed [ACC_W-1:0] comb_out [5];
  logic res_valid_ff;
  logic [RESULT_W-1:0] res_ff;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [RESULT_W-1:0] buf_out_data;
  logic dec_done;
  logic shreg_full_ff;
  logic have_result;

  // ----------------------------------------------------------------------------
  // Serial clock synchroniser and edge detection
  // ----------------------------------------------------------------------------
  // Only the second and third stages feed the edge detector.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_sync_ff <= 3'h0;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], sclk};
    end
  end
  assign sclk_rise = sclk_sync_ff[1] && !sclk_sync_ff[2];
  assign sclk_fall = !sclk_sync_ff[1] && sclk_sync_ff[2];

  // ----------------------------------------------------------------------------
  // Supply monitor glitch filter
  // ----------------------------------------------------------------------------
  // A low-supply flag must persist before it counts as a power-on reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      glitch_cnt_ff <= '0;
    end else if (!(dvdd_low || avdd_low)) begin
      glitch_cnt_ff <= '0;
    end else if (glitch_cnt_ff != GLITCH_CYCLES[$bits(glitch_cnt_ff)-1:0]) begin
      glitch_cnt_ff <= glitch_cnt_ff + 1'b1;
    end
  end
  assign por_event = (glitch_cnt_ff == GLITCH_CYCLES[$bits(glitch_cnt_ff)-1:0]);

  // ----------------------------------------------------------------------------
  // Oscillator control and modulator clock divider
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_en <= 1'b1;
    end else begin
      osc_en <= !ext_clk_seen;
    end
  end

  // The modulator clock stops in sleep to save power; it keeps running during calibration.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_ff <= '0;
      mod_clk <= 1'b0;
    end else if (state_ff == ST_SLEEP) begin
      div_ff <= '0;
      mod_clk <= 1'b0;
    end else begin
      div_ff <= div_ff + 1'b1;
      mod_clk <= div_ff[DIV_W-1];
    end
  end
  assign mod_tick = (div_ff == '1);
  assign filt_run = (state_ff != ST_SLEEP) && (state_ff != ST_CAL);

  // ----------------------------------------------------------------------------
  // Fourth-order comb decimation filter
  // ----------------------------------------------------------------------------
  assign dec_done = mod_tick && (dec_cnt_ff == 32'(DECIM - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_cnt_ff <= '0;
    end else if (!filt_run) begin
      dec_cnt_ff <= '0;
    end else if (mod_tick) begin
      dec_cnt_ff <= dec_done ? '0 : dec_cnt_ff + 1'b1;
    end
  end

  // Integrators run at the modulator rate; the input bit maps to plus or minus one.
  // Single-cycle operation clears the history after each result so every result is fresh.
  assign comb_out[0] = integ_ff[3];
  for (genvar i = 0; i < 4; i++) begin : g_stage
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        integ_ff[i] <= '0;
        comb_dly_ff[i] <= '0;
      end else if (!filt_run || (dec_done && single_ff)) begin
        integ_ff[i] <= '0;
        comb_dly_ff[i] <= '0;
      end else if (mod_tick) begin
        if (i == 0) begin
          integ_ff[i] <= integ_ff[i] + (mod_bit ? ACC_W'(1) : -ACC_W'(1));
        end else begin
          integ_ff[i] <= integ_ff[i] + integ_ff[i-1];
        end
        if (dec_done) begin
          comb_dly_ff[i] <= comb_out[i];
        end
      end
    end
    assign comb_out[i+1] = comb_out[i] - comb_dly_ff[i];
  end

  // Scale to 18 bits and clip the single positive full-scale code.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      res_valid_ff <= 1'b0;
      res_ff <= '0;
    end else if (dec_done && filt_run) begin
      res_valid_ff <= 1'b1;
      if ((comb_out[4] >>> SHIFT) > $signed({1'b0, RESULT_MAX})) begin
        res_ff <= RESULT_MAX;
      end else begin
        res_ff <= RESULT_W'(comb_out[4] >>> SHIFT);
      end
    end else if (buf_in_ready) begin
      res_valid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------------------
  adcr_buf2 #(
    .W(RESULT_W)
  ) u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(res_valid_ff),
    .in_ready(buf_in_ready),
    .in_data(res_ff),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );
  // The shifter accepts a word only while no frame is being shifted.
  assign buf_out_ready = (state_ff == ST_WAIT) || (state_ff == ST_READY);

  // ----------------------------------------------------------------------------
  // Readout, sleep and calibration sequencer
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_CAL;
      timer_ff <= '0;
      pulse_cnt_ff <= '0;
      cal_after_wake_ff <= 1'b0;
      single_ff <= 1'b0;
    end else if (por_event) begin
      state_ff <= ST_CAL;
      timer_ff <= '0;
      pulse_cnt_ff <= '0;
      cal_after_wake_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_WAIT: begin
          // After the 25th pulse a long high is the sleep-with-calibration request.
          timer_ff <= (sclk_sync_ff[2] && pulse_cnt_ff == PULSE_IDLE) ? timer_ff + 1'b1 : '0;
          if (pulse_cnt_ff == PULSE_IDLE && sclk_sync_ff[2] && timer_ff == 32'(SLEEP_CYC - 1)) begin
            state_ff <= ST_SLEEP;
            single_ff <= 1'b1;
            cal_after_wake_ff <= 1'b1;
          end else if (sclk_fall) begin
            pulse_cnt_ff <= '0;
            if (pulse_cnt_ff + 1'b1 == PULSE_CAL) begin
              state_ff <= ST_CAL;
              timer_ff <= '0;
            end else if (have_result) begin
              state_ff <= ST_READY;
            end
          end else if (dec_done && !sclk_sync_ff[2]) begin
            // A fresh result while the clock idles low ends the chance of a 26th pulse.
            pulse_cnt_ff <= '0;
          end
        end
        ST_READY, ST_SHIFT: begin
          timer_ff <= sclk_sync_ff[2] ? timer_ff + 1'b1 : '0;
          if (sclk_sync_ff[2] && timer_ff == 32'(SLEEP_CYC - 1)) begin
            state_ff <= ST_SLEEP;
            single_ff <= 1'b1;
            cal_after_wake_ff <= 1'b0;
          end else if (sclk_fall) begin
            pulse_cnt_ff <= pulse_cnt_ff + 1'b1;
            state_ff <= ST_SHIFT;
            if (pulse_cnt_ff + 1'b1 == PULSE_IDLE) begin
              // The 25th pulse ends the frame; a 26th is then taken in the wait state.
              state_ff <= ST_WAIT;
              single_ff <= 1'b0;
            end
          end
        end
        ST_SLEEP: begin
          timer_ff <= '0;
          pulse_cnt_ff <= '0;
          if (!sclk_sync_ff[2]) begin
            state_ff <= cal_after_wake_ff ? ST_CAL : ST_WAIT;
            cal_after_wake_ff <= 1'b0;
          end
        end
        ST_CAL: begin
          pulse_cnt_ff <= '0;
          timer_ff <= timer_ff + 1'b1;
          if (timer_ff == 32'(CAL_CYC - 1)) begin
            state_ff <= ST_WAIT;
            timer_ff <= '0;
          end
        end
      endcase
    end
  end

  // Leaving the ready phase early means the frame was abandoned; the shifter reloads.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shreg_ff <= '0;
    end else if (buf_out_valid && buf_out_ready) begin
      shreg_ff <= buf_out_data;
    end
  end

  // The shifter holds an unsent word until its frame starts or calibration or sleep clears it, so ready is never lost to a drained buffer.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shreg_full_ff <= 1'b0;
    end else if (state_ff == ST_SHIFT || state_ff == ST_CAL || state_ff == ST_SLEEP) begin
      shreg_full_ff <= 1'b0;
    end else if (buf_out_valid && buf_out_ready) begin
      shreg_full_ff <= 1'b1;
    end
  end
  assign have_result = shreg_full_ff || buf_out_valid;

  // ----------------------------------------------------------------------------
  // Output line
  // ----------------------------------------------------------------------------
  // The line only moves on a falling serial edge, except sleep and calibration force it high.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_dout <= 1'b1;
    end else if (state_ff == ST_SLEEP || state_ff == ST_CAL) begin
      rdy_dout <= 1'b1;
    end else if (state_ff == ST_WAIT && have_result && sclk_fall && pulse_cnt_ff != PULSE_IDLE) begin
      rdy_dout <= 1'b0;
    end else if (state_ff != ST_WAIT && sclk_fall) begin
      if (pulse_cnt_ff < PULSE_LAST_BIT) begin
        rdy_dout <= shreg_ff[RESULT_W - 1 - int'(pulse_cnt_ff)];
      end else if (pulse_cnt_ff + 1'b1 == PULSE_IDLE) begin
        rdy_dout <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_busy <= 1'b1;
    end else begin
      cal_busy <= (state_ff == ST_CAL);
    end
  end

endmodule : adcr_readout

// File: rtl/adcr_pkg.sv
// Shared constants and types for the two-wire converter readout control block.
package adcr_pkg;

  // ----------------------------------------------------------------------------
  // Clocking and timing
  // ----------------------------------------------------------------------------
  localparam longint SYS_CLK_HZ = 250_000_000;
  localparam longint NS_PER_S = 1_000_000_000;
  localparam longint US_PER_S = 1_000_000;
  // Modulator sample clock is the system clock divided by this ratio.
  localparam int MOD_DIV = 64;
  // Result rates in hundredths of a sample per second.
  localparam longint RATE_FAST_CSPS = 12000;
  localparam longint RATE_SLOW_CSPS = 1375;
  localparam int DECIM_FAST = int'((SYS_CLK_HZ * 100) / (MOD_DIV * RATE_FAST_CSPS));
  localparam int DECIM_SLOW = int'((SYS_CLK_HZ * 100) / (MOD_DIV * RATE_SLOW_CSPS));
  // Calibration time is the calibrate-plus-convert time less one conversion.
  localparam longint CAL_CNV_TIME_US = 208300;
  localparam longint CONV_TIME_US = 8600;
  localparam int CAL_CYCLES = int'(((CAL_CNV_TIME_US - CONV_TIME_US) * SYS_CLK_HZ) / US_PER_S);
  // Serial clock held high this long after ready puts the device to sleep.
  localparam longint SLEEP_HOLD_US = 100;
  localparam int SLEEP_CYCLES = int'((SLEEP_HOLD_US * SYS_CLK_HZ) / US_PER_S);
  // Supply monitor flags shorter than this are treated as glitches.
  localparam longint GLITCH_NS = 1000;
  localparam int GLITCH_CYCLES = int'((GLITCH_NS * SYS_CLK_HZ + NS_PER_S - 1) / NS_PER_S);

  // ----------------------------------------------------------------------------
  // Result framing
  // ----------------------------------------------------------------------------
  localparam int RESULT_W = 18;
  localparam int PCNT_W = 5;
  localparam logic [PCNT_W-1:0] PULSE_LAST_BIT = 5'h12;
  localparam logic [PCNT_W-1:0] PULSE_IDLE = 5'h19;
  localparam logic [PCNT_W-1:0] PULSE_CAL = 5'h1A;
  localparam logic [RESULT_W-1:0] RESULT_MAX = 18'h1_FFFF;

  // Readout and sleep sequencer states.
  typedef enum logic [2:0] {
    ST_WAIT,
    ST_READY,
    ST_SHIFT,
    ST_SLEEP,
    ST_CAL
  } adcr_state_type;

endpackage : adcr_pkg

// File: rtl/adcr_buf2.sv
// Two-entry valid/ready buffer between the decimator and the output shifter.
`timescale 1ns/1ps
module adcr_buf2 #(
  parameter int W = 18
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] mem_ff [2];
  logic rd_ptr_ff;
  logic wr_ptr_ff;
  logic [1:0] count_ff;
  logic push;
  logic pop;

  // Handshakes happen only when both sides agree.
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Occupancy and pointers; full refuses the writer so no word is lost.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= 2'h0;
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
    end else begin
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
    end
  end

  // Storage has no reset; the count guards against reading stale words.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  assign in_ready = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign out_data = mem_ff[rd_ptr_ff];

endmodule : adcr_buf2

// File: verif/adcr_readout_assertions.sv
// Port-level concurrent checks for the converter readout block.
`timescale 1ns/1ps
module adcr_readout_assertions #(
  parameter int CAL_CYC = 200,
  parameter int SLEEP_CYC = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Supplies and clock source
  input wire logic dvdd_low,
  input wire logic avdd_low,
  input wire logic ext_clk_seen,
  input wire logic osc_en,
  // Modulator side
  input wire logic mod_clk,
  input wire logic mod_bit,
  input wire logic cal_busy,
  // Host link
  input wire logic sclk,
  input wire logic rdy_dout
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic sclk_d_ff;
  logic [7:0] fall_age_ff;
  logic [7:0] hi_cnt_ff;
  logic [9:0] sup_cnt_ff;
  logic [6:0] mod_hi_ff;
  logic [31:0] cal_len_ff;

  // Ages saturate so a long idle stretch never wraps into a false match.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d_ff <= 1'h0;
      fall_age_ff <= 8'hFF;
      hi_cnt_ff <= 8'h00;
      sup_cnt_ff <= 10'h000;
      mod_hi_ff <= 7'h00;
      cal_len_ff <= 32'h0000_0000;
    end else begin
      sclk_d_ff <= sclk;
      fall_age_ff <= (sclk_d_ff && !sclk) ? 8'h00 : fall_age_ff + {7'h00, fall_age_ff != 8'hFF};
      hi_cnt_ff <= sclk ? hi_cnt_ff + {7'h00, hi_cnt_ff != 8'hFF} : 8'h00;
      sup_cnt_ff <= (dvdd_low || avdd_low) ? sup_cnt_ff + {9'h000, sup_cnt_ff != 10'h3FF} : 10'h000;
      mod_hi_ff <= mod_clk ? mod_hi_ff + 7'h01 : 7'h00;
      cal_len_ff <= cal_busy ? cal_len_ff + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A falling serial clock edge was seen within the last few cycles.
  sequence s_recent_fall;
    fall_age_ff >= 8'h01 && fall_age_ff <= 8'h08;
  endsequence
  // A modulator high phase begins away from sleep, calibration and faults.
  sequence s_clean_rise;
    $rose(mod_clk) && hi_cnt_ff < 8'h1E && !cal_busy && sup_cnt_ff == 10'h000 && fall_age_ff > 8'h10;
  endsequence

  chk_osc_follow:
    assert property (osc_en == !$past(ext_clk_seen)) else $error("oscillator enable does not follow detect");
  chk_fall_on_edge:
    assert property ($fell(rdy_dout) |-> s_recent_fall) else $error("ready line fell without a clock fall");
  chk_rise_cause:
    assert property ($rose(rdy_dout) |-> (fall_age_ff >= 8'h01 && fall_age_ff <= 8'h08) || cal_busy
      || hi_cnt_ff > 8'h28 || sup_cnt_ff >= 10'h0F0) else $error("ready line rose without a cause");
  chk_ready_not_cal:
    assert property ($fell(rdy_dout) |-> !cal_busy) else $error("ready signalled during calibration");
  chk_cal_line_high:
    assert property (cal_busy && $past(cal_busy) |-> rdy_dout) else $error("line low during calibration");
  chk_cal_length:
    assert property ($fell(cal_busy) |-> int'(cal_len_ff) >= CAL_CYC - 2) else $error("calibration too short");
  chk_glitch_ignore:
    assert property ($rose(cal_busy) |-> sup_cnt_ff >= 10'h0F0 || fall_age_ff <= 8'h0C)
      else $error("calibration started without a cause");
  chk_supply_restart:
    assert property (sup_cnt_ff == 10'h10E |-> cal_busy) else $error("held supply fault did not recalibrate");
  chk_sleep_high:
    assert property (int'(hi_cnt_ff) == SLEEP_CYC + 30 |-> rdy_dout) else $error("line low in sleep");
  chk_mod_hold:
    assert property (s_clean_rise |=> mod_clk [*8]) else $error("modulator clock high phase cut short");
  chk_mod_period:
    assert property ($fell(mod_clk) && hi_cnt_ff < 8'h1E && !cal_busy && sup_cnt_ff == 10'h000
      |-> mod_hi_ff == 7'h20) else $error("modulator clock half period wrong");
endmodule : adcr_readout_assertions

// File: verif/adcr_host_model.sv
// Host controller model that makes the serial clock and samples the ready/data line.
`timescale 1ns/1ps
module adcr_host_model (
  // Clock
  input wire logic clk,
  // Host link
  output logic sclk,
  input wire logic rdy_dout
);
  // The host alone owns the serial clock and idles it low between frames.
  initial sclk = 1'h0;

  // One pulse; the line is sampled late in the low half, after the update has landed.
  task automatic pulse(input int half, output logic bit_seen);
    sclk <= 1'h1;
    repeat (half) @(posedge clk);
    sclk <= 1'h0;
    repeat (half) @(posedge clk);
    bit_seen = rdy_dout;
  endtask : pulse

  // A read frame of n pulses; 25 returns the line high, 26 also asks for calibration.
  task automatic frame(input int half, input int n, output logic [25:0] bits);
    for (int k = 0; k < n; k++) begin
      pulse(half, bits[k]);
    end
  endtask : frame

  // Pulses until the line is low; bounded so a dead device cannot hang the host.
  task automatic wait_ready(output logic ok);
    logic b;
    b = rdy_dout;
    for (int n = 0; n < 700 && b !== 1'h0; n++) begin
      pulse(8, b);
    end
    ok = (b === 1'h0);
  endtask : wait_ready

  // Holds the clock high; a long hold after ready is the sleep request.
  task automatic hold_high(input int n);
    sclk <= 1'h1;
    repeat (n) @(posedge clk);
  endtask : hold_high

  // Pulls the clock low, which wakes a sleeping device.
  task automatic release_low();
    sclk <= 1'h0;
    @(posedge clk);
  endtask : release_low
endmodule : adcr_host_model

// File: verif/adcr_readout_bench.sv
// Self-checking testbench for the converter readout block.
`timescale 1ns/1ps
module adcr_readout_bench
  import adcr_pkg::*;
;
  localparam int CAL_CYC = 200;
  localparam int SLEEP_CYC = 50;
  localparam int DECIM = 32;
  logic clk, rst_b, dvdd_low, avdd_low, ext_clk_seen, mod_bit;
  logic sclk, osc_en, mod_clk, cal_busy, rdy_dout;
  int num_errors = 0;
  int total_checks = 0;
  int cycle_count = 0;

  adcr_readout #(.FAST_VARIANT(1'h1), .DECIM(DECIM), .CAL_CYC(CAL_CYC), .SLEEP_CYC(SLEEP_CYC)) dut (
    .clk(clk), .rst_b(rst_b), .dvdd_low(dvdd_low), .avdd_low(avdd_low), .ext_clk_seen(ext_clk_seen),
    .osc_en(osc_en), .mod_clk(mod_clk), .mod_bit(mod_bit), .cal_busy(cal_busy), .sclk(sclk),
    .rdy_dout(rdy_dout));
  adcr_host_model host (.clk(clk), .sclk(sclk), .rdy_dout(rdy_dout));

  // ----------------------------------------------------------------
  // Clock, watchdog and reporting
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 90000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_clock_source();
    ext_clk_seen <= 1'h1;
    repeat (2) @(posedge clk);
    check("osc off", osc_en, 1'h0);
    ext_clk_seen <= 1'h0;
    repeat (2) @(posedge clk);
    check("osc on", osc_en, 1'h1);
  endtask : t_clock_source

  // Old results are flushed by waiting, so the frame shows the new stream only.
  task automatic t_read(input logic stream, input logic exp_msb, input int half);
    logic [25:0] bits;
    logic ok;
    mod_bit <= stream;
    repeat (6 * 64 * DECIM) @(posedge clk);
    host.wait_ready(ok);
    check("ready", ok, 1'h1);
    host.frame(half, 25, bits);
    check("msb sign", bits[0], exp_msb);
    check("tail", bits[23:18], {6{bits[RESULT_W-1]}});
    check("idle high", bits[24], 1'h1);
  endtask : t_read

  task automatic wait_cal_done();
    for (int n = 0; n < 600 && cal_busy !== 1'h0; n++) begin
      @(posedge clk);
    end
    check("cal done", cal_busy, 1'h0);
  endtask : wait_cal_done

  task automatic t_recal();
    logic [25:0] bits;
    logic ok;
    host.wait_ready(ok);
    host.frame(6, 26, bits);
    check("cal started", {cal_busy, rdy_dout}, 2'h3);
    wait_cal_done();
    host.wait_ready(ok);
    check("ready after cal", ok, 1'h1);
  endtask : t_recal

  task automatic t_sleep();
    logic [25:0] bits;
    logic ok;
    logic seen_mod;
    host.wait_ready(ok);
    host.hold_high(SLEEP_CYC + 40);
    check("sleep line", rdy_dout, 1'h1);
    seen_mod = 1'h0;
    for (int n = 0; n < 70; n++) begin
      @(posedge clk);
      seen_mod = seen_mod | mod_clk;
    end
    check("mod stopped", seen_mod, 1'h0);
    host.release_low();
    host.wait_ready(ok);
    check("wake ready", {ok, cal_busy}, 2'h2);
    host.frame(8, 25, bits);
    host.hold_high(SLEEP_CYC + 40);
    host.release_low();
    repeat (8) @(posedge clk);
    check("wake cal", cal_busy, 1'h1);
    wait_cal_done();
  endtask : t_sleep

  task automatic t_supply();
    logic ok;
    dvdd_low <= 1'h1;
    repeat (100) @(posedge clk);
    dvdd_low <= 1'h0;
    repeat (20) @(posedge clk);
    check("glitch", cal_busy, 1'h0);
    avdd_low <= 1'h1;
    repeat (300) @(posedge clk);
    check("fault cal", cal_busy, 1'h1);
    avdd_low <= 1'h0;
    wait_cal_done();
    host.wait_ready(ok);
    check("ready after fault", ok, 1'h1);
  endtask : t_supply

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'h0;
    dvdd_low = 1'h0;
    avdd_low = 1'h0;
    ext_clk_seen = 1'h0;
    mod_bit = 1'h0;
    repeat (8) @(posedge clk);
    check("reset outputs", {rdy_dout, osc_en, mod_clk, cal_busy}, 4'hD);
    rst_b <= 1'h1;
    @(posedge clk);
    t_clock_source();
    t_read(1'h1, 1'h0, 12);
    t_read(1'h0, 1'h1, 6);
    t_recal();
    t_sleep();
    t_supply();
    report_and_stop();
  end
endmodule : adcr_readout_bench

bind adcr_readout adcr_readout_assertions #(.CAL_CYC(CAL_CYC), .SLEEP_CYC(SLEEP_CYC)) chk (
  .clk(clk), .rst_b(rst_b), .dvdd_low(dvdd_low), .avdd_low(avdd_low), .ext_clk_seen(ext_clk_seen),
  .osc_en(osc_en), .mod_clk(mod_clk), .mod_bit(mod_bit), .cal_busy(cal_busy), .sclk(sclk),
  .rdy_dout(rdy_dout));
